// *** hw/urea_pkg.sv ***
// Purpose: Shared constants and types for the serial receive status block
// Assumes: One clock, mclk at 250 MHz
// Notes:   Register offsets are byte addresses, one register every four bytes
`default_nettype none

package urea_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_HZ     = 250_000_000;
  localparam int unsigned BAUD_RATE  = 115_200;
  localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_RATE;
  localparam int unsigned CNT_W      = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Character and buffer shape
  localparam int unsigned CHAR_W     = 9;
  localparam int unsigned FIFO_DEPTH = 2;
  localparam int unsigned PTR_W      = $clog2(FIFO_DEPTH);
  localparam int unsigned CNT_FW     = $clog2(FIFO_DEPTH + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Register port
  localparam int unsigned ADDR_W       = 8;
  localparam int unsigned DATA_W       = 8;
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_STATUS   = 8'h04;
  localparam logic [7:0]  OFS_DATA     = 8'h08;
  localparam logic [7:0]  OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0]  OFS_IRQ_MASK = 8'h10;

  // Control fields
  localparam int unsigned CTRL_SERIAL_PORT_ENABLE_BIT  = 0;
  localparam int unsigned CTRL_CONTINUOUS_RX_ENABLE_BIT  = 1;
  localparam int unsigned CTRL_RX9_BIT   = 2;
  localparam int unsigned CTRL_ADDRESS_DETECT_ENABLE_BIT = 3;

  // Status fields
  localparam int unsigned ST_NINTH_BIT = 0;
  localparam int unsigned ST_OVR_BIT   = 1;
  localparam int unsigned ST_FRAME_ERR_FLAG_BIT  = 2;
  localparam int unsigned ST_RXIF_BIT  = 3;

  // Interrupt events
  localparam int unsigned IRQ_W       = 2;
  localparam int unsigned IRQ_RX_BIT  = 0;
  localparam int unsigned IRQ_OVR_BIT = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {PH_IDLE, PH_START, PH_DATA, PH_STOP} urea_phase_t;

  typedef struct packed {
    logic              frame_err_flag;
    logic [CHAR_W-1:0] data;
  } urea_entry_t;

endpackage

`default_nettype wire

// *** hw/urea_line_if.sv ***
// Purpose: Serial line between the remote transmitter and the receiver
// Assumes: Line idles high; one driver, the remote end
// Notes:   No clocking block; both ends sample on mclk
`default_nettype none

interface urea_line_if;
  logic line;

  modport device (input line);
  modport remote (output line);
endinterface

`default_nettype wire

// *** hw/urea_rx_shift.sv ***
// Purpose: Receive shift register: start check, data sampling, stop check
// Assumes: rxd synchronous to mclk; run low holds the shifter idle
// Notes:   Samples each bit at its middle; done is a one-cycle pulse
`default_nettype none

module urea_rx_shift
  import urea_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = urea_pkg::BIT_CYCLES
)(
  input  wire logic                        mclk,
  input  wire logic                        arst_n,
  input  wire logic                        clk_en,
  input  wire logic                        run,
  input  wire logic                        nine_bit,
  input  wire logic                        rxd,
  output logic                             done,
  output logic [urea_pkg::CHAR_W-1:0]      data,
  output logic                             frame_err_flag
);

  localparam logic [CNT_W-1:0] FULL = CNT_W'(BIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] HALF = CNT_W'(BIT_CYCLES / 2 - 1);

  typedef struct packed {
    urea_phase_t       phase;
    logic [CNT_W-1:0]  cnt;
    logic [3:0]        idx;
    logic [CHAR_W-1:0] shift;
    logic              prev;
    logic              done;
    logic [CHAR_W-1:0] data;
    logic              frame_err_flag;
  } urea_shift_t;

  urea_shift_t s;
  urea_shift_t n;
  logic [3:0]  last_idx;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    n        = s;
    n.done   = 1'b0;
    n.prev   = rxd;
    last_idx = nine_bit ? 4'h8 : 4'h7; // RULE_12
    case (s.phase)
      PH_IDLE:
      begin
        // Falling edge only, so a held-low line cannot restart forever
        if (s.prev && !rxd)
        begin
          n.phase = PH_START;
          n.cnt   = HALF;
        end
      end
      PH_START:
      begin
        if (s.cnt == '0)
        begin
          // Glitch rejection: start must still be low at mid-bit
          n.phase = rxd ? PH_IDLE : PH_DATA;
          n.cnt   = FULL;
          n.idx   = 4'h0;
        end
        else
          n.cnt = s.cnt - 1'b1;
      end
      PH_DATA:
      begin
        if (s.cnt == '0)
        begin
          n.shift = {rxd, s.shift[CHAR_W-1:1]};
          n.cnt   = FULL;
          n.idx   = s.idx + 1'b1;
          if (s.idx == last_idx)
            n.phase = PH_STOP;
        end
        else
          n.cnt = s.cnt - 1'b1;
      end
      PH_STOP:
      begin
        if (s.cnt == '0)
        begin
          n.phase = PH_IDLE;
          n.done  = 1'b1;
          n.frame_err_flag  = !rxd; // RULE_01
          n.data  = nine_bit ? s.shift : {1'b0, s.shift[CHAR_W-1:1]}; // RULE_12
        end
        else
          n.cnt = s.cnt - 1'b1;
      end
      default: n.phase = PH_IDLE;
    endcase
    if (!run)
      n.phase = PH_IDLE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      s <= '0;
    else if (clk_en)
      s <= n;
  end

  assign done = s.done;
  assign data = s.data;
  assign frame_err_flag = s.frame_err_flag;

endmodule

`default_nettype wire

// *** hw/urea_tx_remote.sv ***
// Purpose: Remote transmitter end driving the shared serial line
// Assumes: Same bit time as the receiver
// Notes:   send_bad_stop drives a low stop bit to provoke a framing error
`default_nettype none

module urea_tx_remote
  import urea_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = urea_pkg::BIT_CYCLES
)(
  input  wire logic                        mclk,
  input  wire logic                        arst_n,
  input  wire logic                        clk_en,
  urea_line_if.remote                      link,
  input  wire logic                        send,
  input  wire logic [urea_pkg::CHAR_W-1:0] send_data,
  input  wire logic                        send_nine,
  input  wire logic                        send_bad_stop,
  output logic                             ready
);

  localparam logic [CNT_W-1:0] FULL = CNT_W'(BIT_CYCLES - 1);

  typedef struct packed {
    urea_phase_t       phase;
    logic [CNT_W-1:0]  cnt;
    logic [3:0]        idx;
    logic [CHAR_W-1:0] shift;
    logic              nine;
    logic              bad;
    logic              txd;
  } urea_tx_t;

  localparam urea_tx_t TX_RST = '{phase: PH_IDLE, cnt: '0, idx: '0, shift: '0,
                                  nine: 1'b0, bad: 1'b0, txd: 1'b1};

  urea_tx_t   s;
  urea_tx_t   n;
  logic [3:0] last_idx;

  ////////////////////////////////////////////////////////////////////////////
  // Next state: start, 8 or 9 data bits LSB first, stop
  always_comb
  begin
    n        = s;
    last_idx = s.nine ? 4'h8 : 4'h7;
    case (s.phase)
      PH_IDLE:
      begin
        if (send)
        begin
          n.phase = PH_START;
          n.cnt   = FULL;
          n.shift = send_data;
          n.nine  = send_nine;
          n.bad   = send_bad_stop;
          n.txd   = 1'b0;
        end
      end
      PH_START:
      begin
        if (s.cnt == '0)
        begin
          n.phase = PH_DATA;
          n.cnt   = FULL;
          n.idx   = 4'h0;
          n.txd   = s.shift[0];
        end
        else
          n.cnt = s.cnt - 1'b1;
      end
      PH_DATA:
      begin
        if (s.cnt == '0)
        begin
          n.cnt = FULL;
          if (s.idx == last_idx)
          begin
            n.phase = PH_STOP;
            n.txd   = !s.bad;
          end
          else
          begin
            n.shift = {1'b0, s.shift[CHAR_W-1:1]};
            n.txd   = s.shift[1];
            n.idx   = s.idx + 1'b1;
          end
        end
        else
          n.cnt = s.cnt - 1'b1;
      end
      PH_STOP:
      begin
        if (s.cnt == '0)
        begin
          n.phase = PH_IDLE;
          n.txd   = 1'b1;
        end
        else
          n.cnt = s.cnt - 1'b1;
      end
      default: n = TX_RST;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      s <= TX_RST;
    else if (clk_en)
      s <= n;
  end

  assign ready     = (s.phase == PH_IDLE);
  assign link.line = s.txd;

endmodule

`default_nettype wire

// *** hw/urea_rx_device.sv ***
// Purpose: Receiver end with two-deep FIFO, error flags and address filter
// Assumes: Line synchronous to mclk; register reads answer one cycle later
// Notes:   Reading the data register pops the FIFO; read status first
//
// Summary of operation
// RULE_01: Every FIFO entry keeps its own framing error.
// RULE_02: Framing flag shows the oldest unread character.
// RULE_03: Framing errors never stop further reception.
// RULE_04: Data read pops FIFO, flag follows next.
// RULE_05: Port enable low resets all, framing flag zero.
// RULE_06: Receive enable low leaves framing flag alone.
// RULE_07: Framing error alone raises no interrupt.
// RULE_08: All-bad FIFO keeps framing flag set across reads.
// RULE_09: Two entries; third complete character sets overrun.
// RULE_10: Overrun stops reception, held characters stay readable.
// RULE_11: Overrun cleared only by either enable going low.
// RULE_12: Nine-bit option shifts nine data bits.
// RULE_13: Ninth bit of oldest character, read before popping.
// RULE_14: Address filter enabled by bit, needs nine-bit mode.
// RULE_15: Filter keeps only characters with ninth bit set.
// RULE_16: Software drops filter before next stop bit.
// RULE_17: Software re-arms filter when message ends.
// RULE_18: Receive flag high while FIFO holds a character.
//
// Our own choices: the address-and-strobe port and the address map.
`default_nettype none

module urea_rx_device
  import urea_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = urea_pkg::BIT_CYCLES
)(
  input  wire logic                        mclk,
  input  wire logic                        arst_n,
  input  wire logic                        clk_en,
  urea_line_if.device                      link,
  input  wire logic [urea_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [urea_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic [urea_pkg::DATA_W-1:0]      reg_rdata,
  output logic                             irq
);

  typedef struct packed {
    logic                             serial_port_enable;
    logic                             continuous_rx_enable;
    logic                             nine_bit_rx_select;
    logic                             address_detect_enable;
    logic                             overrun_err_flag;
    urea_entry_t [FIFO_DEPTH-1:0]     fifo;
    logic [PTR_W-1:0]                 rd_ptr;
    logic [PTR_W-1:0]                 wr_ptr;
    logic [CNT_FW-1:0]                count;
    logic [IRQ_W-1:0]                 irq_stat;
    logic [IRQ_W-1:0]                 irq_mask;
    logic [DATA_W-1:0]                rdata;
  } urea_dev_t;

  urea_dev_t         s;
  urea_dev_t         n;
  urea_entry_t       head;
  logic              has_char;
  logic              full;
  logic              pop;
  logic              keep;
  logic              accept;
  logic              overrun;
  logic              run;
  logic [IRQ_W-1:0]  ev;
  logic [IRQ_W-1:0]  clr;
  logic              sh_done;
  logic [CHAR_W-1:0] sh_data;
  logic              sh_frame_err_flag;

  ////////////////////////////////////////////////////////////////////////////
  // Shifter runs only while enabled and free of overrun
  assign run = s.serial_port_enable && s.continuous_rx_enable && !s.overrun_err_flag; // RULE_10

  urea_rx_shift #(
    .BIT_CYCLES (BIT_CYCLES)
  ) u_shift (
    .mclk     (mclk),
    .arst_n   (arst_n),
    .clk_en   (clk_en),
    .run      (run),
    .nine_bit (s.nine_bit_rx_select),
    .rxd      (link.line),
    .done     (sh_done),
    .data     (sh_data),
    .frame_err_flag     (sh_frame_err_flag)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    n        = s;
    n.rdata  = '0;
    clr      = '0;
    ev       = '0;
    head     = s.fifo[s.rd_ptr]; // RULE_02
    has_char = (s.count != '0);
    full     = (s.count == CNT_FW'(FIFO_DEPTH)); // RULE_09
    pop      = reg_rd && (reg_addr == OFS_DATA) && has_char; // RULE_04
    // Filter decided at the stop sample, so software has until then
    keep     = sh_done && !(s.address_detect_enable && s.nine_bit_rx_select // RULE_14
                            && !sh_data[CHAR_W-1]); // RULE_15 RULE_16
    // A pop in the same cycle counts as the FIFO being accessed
    accept   = keep && (!full || pop); // RULE_03
    overrun  = keep && full && !pop; // RULE_09
    ev[IRQ_RX_BIT]  = accept;
    ev[IRQ_OVR_BIT] = overrun; // RULE_07

    // Register reads, data stands in the following cycle
    if (reg_rd)
    begin
      case (reg_addr)
        OFS_CTRL:
        begin
          n.rdata[CTRL_SERIAL_PORT_ENABLE_BIT]  = s.serial_port_enable;
          n.rdata[CTRL_CONTINUOUS_RX_ENABLE_BIT]  = s.continuous_rx_enable;
          n.rdata[CTRL_RX9_BIT]   = s.nine_bit_rx_select;
          n.rdata[CTRL_ADDRESS_DETECT_ENABLE_BIT] = s.address_detect_enable;
        end
        OFS_STATUS:
        begin
          n.rdata[ST_NINTH_BIT] = has_char && head.data[CHAR_W-1]; // RULE_13
          n.rdata[ST_OVR_BIT]   = s.overrun_err_flag;
          n.rdata[ST_FRAME_ERR_FLAG_BIT]  = has_char && head.frame_err_flag; // RULE_02 RULE_08
          n.rdata[ST_RXIF_BIT]  = has_char; // RULE_18
        end
        OFS_DATA:     n.rdata = has_char ? head.data[DATA_W-1:0] : '0;
        OFS_IRQ_STAT: n.rdata = DATA_W'(s.irq_stat);
        OFS_IRQ_MASK: n.rdata = DATA_W'(s.irq_mask);
        default:      n.rdata = '0;
      endcase
    end

    // Register writes
    if (reg_wr)
    begin
      case (reg_addr)
        OFS_CTRL:
        begin
          n.serial_port_enable    = reg_wdata[CTRL_SERIAL_PORT_ENABLE_BIT];
          n.continuous_rx_enable  = reg_wdata[CTRL_CONTINUOUS_RX_ENABLE_BIT];
          n.nine_bit_rx_select    = reg_wdata[CTRL_RX9_BIT];
          n.address_detect_enable = reg_wdata[CTRL_ADDRESS_DETECT_ENABLE_BIT]; // RULE_17
        end
        OFS_IRQ_STAT: clr = reg_wdata[IRQ_W-1:0];
        OFS_IRQ_MASK: n.irq_mask = reg_wdata[IRQ_W-1:0];
        default:      ;
      endcase
    end

    // Sticky events, a new event beats a same-cycle clear
    n.irq_stat = (s.irq_stat & ~clr) | ev;

    // FIFO movement; pointers wrap on their own only because the depth
    // is a power of two, a deeper odd-sized buffer needs explicit wrap
    if (pop)
      n.rd_ptr = s.rd_ptr + 1'b1; // RULE_04
    if (accept)
    begin
      n.fifo[s.wr_ptr] = '{frame_err_flag: sh_frame_err_flag, data: sh_data}; // RULE_01
      n.wr_ptr         = s.wr_ptr + 1'b1;
    end
    if (accept && !pop)
      n.count = s.count + 1'b1;
    else if (pop && !accept)
      n.count = s.count - 1'b1;

    // Overrun: set by a lost character, cleared by either enable
    if (overrun)
      n.overrun_err_flag = 1'b1;
    if (!s.continuous_rx_enable)
      n.overrun_err_flag = 1'b0; // RULE_11 RULE_06

    // Port disable empties everything, framing flag reads zero
    if (!s.serial_port_enable)
    begin
      n.overrun_err_flag = 1'b0; // RULE_11
      n.fifo             = '0; // RULE_05
      n.rd_ptr           = '0;
      n.wr_ptr           = '0;
      n.count            = '0;
      n.irq_stat         = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; clock enable freezes everything
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      s <= '0;
    else if (clk_en)
      s <= n;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata = s.rdata;
  assign irq       = |(s.irq_stat & s.irq_mask);

endmodule

`default_nettype wire

// *** test/urea_checker.sv ***
// Purpose: Concurrent checks on the serial line and the register port
// Assumes: One clock domain; BIT_CYCLES of at least 8 in the bench
// Notes:   Plain signal inputs, instantiated beside the line interface
`default_nettype none

module urea_checker
  import urea_pkg::*;
(
  input wire logic                        mclk,
  input wire logic                        arst_n,
  input wire logic                        line,
  input wire logic                        ready,
  input wire logic                        send,
  input wire logic [urea_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [urea_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                        reg_wr,
  input wire logic                        reg_rd,
  input wire logic [urea_pkg::DATA_W-1:0] reg_rdata,
  input wire logic                        irq
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  ////////////////////////////////////////////////////////////////////////////
  // Frame steps on the line
  sequence start_bit_s;
    !line && !ready;
  endsequence
  sequence bit_hold_s;
    !line [*8];
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // Register port and interrupt
  rdata_quiet_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data seen outside a read answer");
  status_rsvd_a: assert property (reg_rd && reg_addr == OFS_STATUS |=> reg_rdata[7:4] == 4'h0)
    else $error("status upper bits not zero");
  unmapped_rd_a: assert property (reg_rd && reg_addr == 8'h14 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  // Reads never clear the interrupt; only writes may
  irq_fall_a: assert property ($fell(irq) |-> $past(reg_wr) || $past(reg_wr, 2))
    else $error("interrupt dropped without a write");
  mask_off_a: assert property (reg_wr && reg_addr == OFS_IRQ_MASK && reg_wdata[1:0] == 2'h0 |-> ##2 !irq)
    else $error("interrupt high with mask cleared");
  serial_port_enable_off_a: assert property (reg_wr && reg_addr == OFS_CTRL && !reg_wdata[0] |-> ##3 !irq)
    else $error("interrupt survives port disable");

  ////////////////////////////////////////////////////////////////////////////
  // Line shape from the remote end
  start_bit_a: assert property (send && ready |=> start_bit_s)
    else $error("start bit not driven after send");
  bit_hold_a: assert property ($fell(line) |-> bit_hold_s)
    else $error("low bit shorter than expected");
  line_idle_a: assert property (ready && $past(ready) && $past(ready, 2) |-> line)
    else $error("idle line not high");
endmodule

`default_nettype wire

// *** test/testbench.sv ***
// Purpose: Self-checking bench joining remote transmitter and receiver
// Assumes: BIT_CYCLES shortened to 16; clk_en held high
// Notes:   Status reads must precede data reads, which pop the buffer
`default_nettype none

module testbench;
  import urea_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int unsigned BC = 16;
  logic                mclk = 1'b0;
  logic                arst_n = 1'b0;
  logic [ADDR_W-1:0]   reg_addr = 8'h00;
  logic [DATA_W-1:0]   reg_wdata = 8'h00;
  logic                reg_wr = 1'b0;
  logic                reg_rd = 1'b0;
  logic [DATA_W-1:0]   reg_rdata;
  logic                irq;
  logic                tx_send = 1'b0;
  logic [CHAR_W-1:0]   send_data = 9'h000;
  logic                send_nine = 1'b0;
  logic                send_bad_stop = 1'b0;
  logic                ready;
  int                  err_count = 0;
  int                  checks = 0;
  int                  cyc = 0;

  urea_line_if link_if ();

  urea_tx_remote #(.BIT_CYCLES(BC)) urea_tx_remote_inst (.mclk(mclk), .arst_n(arst_n), .clk_en(1'b1),
    .link(link_if), .send(tx_send), .send_data(send_data), .send_nine(send_nine),
    .send_bad_stop(send_bad_stop), .ready(ready));

  urea_rx_device #(.BIT_CYCLES(BC)) urea_rx_device_inst (.mclk(mclk), .arst_n(arst_n), .clk_en(1'b1),
    .link(link_if), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq));

  urea_checker urea_checker_inst (.mclk(mclk), .arst_n(arst_n), .line(link_if.line), .ready(ready),
    .send(tx_send), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; ceiling far above the few thousand cycles needed
  always #2 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      conclude();
    end
  end

  task automatic conclude();
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("FAIL at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Register port and line stimulus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // Interrupt level, looked at once the launching edge has settled
  task automatic chk_irq(input logic exp);
    #1;
    cmp({7'h0, irq}, {7'h0, exp});
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    cmp(reg_rdata, exp);
  endtask

  task automatic send_char(input logic [8:0] d, input logic nine, input logic bad);
    int n;
    @(posedge mclk);
    tx_send <= 1'b1;
    send_data <= d;
    send_nine <= nine;
    send_bad_stop <= bad;
    @(posedge mclk);
    tx_send <= 1'b0;
    #1;
    n = 0;
    while (ready !== 1'b1 && n < 1000)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    // A remote end that never goes idle counts as a mismatch
    cmp({7'h0, ready}, 8'h01);
    repeat (4) @(posedge mclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_basic();
    wr(OFS_CTRL, 8'h03);
    wr(OFS_IRQ_MASK, 8'h03);
    send_char(9'h05a, 1'b0, 1'b0);
    chk_irq(1'b1);
    chk(OFS_STATUS, 8'h08);
    chk(OFS_DATA, 8'h5a);
    chk(OFS_STATUS, 8'h00);
    chk(8'h14, 8'h00);
    wr(OFS_IRQ_STAT, 8'h03);
    chk_irq(1'b0);
  endtask

  // Bad stop then good char: flag follows the head, reception goes on
  task automatic t_frame_err_flag();
    send_char(9'h0c3, 1'b0, 1'b1);
    send_char(9'h03c, 1'b0, 1'b0);
    chk(OFS_STATUS, 8'h0c);
    chk(OFS_DATA, 8'hc3);
    chk(OFS_STATUS, 8'h08);
    chk(OFS_DATA, 8'h3c);
    chk(OFS_IRQ_STAT, 8'h01);
    wr(OFS_IRQ_STAT, 8'h01);
  endtask

  task automatic t_nine();
    wr(OFS_CTRL, 8'h07);
    send_char(9'h1a5, 1'b1, 1'b0);
    chk(OFS_STATUS, 8'h09);
    chk(OFS_DATA, 8'ha5);
    chk(OFS_STATUS, 8'h00);
  endtask

  // Filter drops ninth-bit-zero chars, then is dropped for data
  task automatic t_addr();
    wr(OFS_CTRL, 8'h0f);
    send_char(9'h033, 1'b1, 1'b0);
    chk(OFS_STATUS, 8'h00);
    send_char(9'h1c4, 1'b1, 1'b0);
    chk(OFS_STATUS, 8'h09);
    wr(OFS_CTRL, 8'h07);
    send_char(9'h011, 1'b1, 1'b0);
    chk(OFS_DATA, 8'hc4);
    chk(OFS_DATA, 8'h11);
    wr(OFS_CTRL, 8'h0f);
    send_char(9'h022, 1'b1, 1'b0);
    chk(OFS_STATUS, 8'h00);
    wr(OFS_CTRL, 8'h03);
  endtask

  // Third char overruns; fourth is lost until receive enable drops
  task automatic t_overrun();
    send_char(9'h001, 1'b0, 1'b0);
    send_char(9'h002, 1'b0, 1'b0);
    send_char(9'h003, 1'b0, 1'b0);
    chk(OFS_STATUS, 8'h0a);
    chk(OFS_DATA, 8'h01);
    chk(OFS_DATA, 8'h02);
    send_char(9'h004, 1'b0, 1'b0);
    chk(OFS_STATUS, 8'h02);
    chk(OFS_IRQ_STAT, 8'h03);
    wr(OFS_CTRL, 8'h01);
    wr(OFS_CTRL, 8'h03);
    chk(OFS_STATUS, 8'h00);
    wr(OFS_IRQ_MASK, 8'h00);
    chk_irq(1'b0);
  endtask

  // All-bad buffer; receive disable keeps flag, port disable clears it
  task automatic t_enable();
    // Unmasked so that the port disable has a live interrupt to drop
    wr(OFS_IRQ_MASK, 8'h03);
    send_char(9'h0aa, 1'b0, 1'b1);
    send_char(9'h055, 1'b0, 1'b1);
    wr(OFS_CTRL, 8'h01);
    chk(OFS_STATUS, 8'h0c);
    chk(OFS_DATA, 8'haa);
    chk(OFS_STATUS, 8'h0c);
    wr(OFS_CTRL, 8'h00);
    chk(OFS_STATUS, 8'h00);
    chk(OFS_IRQ_STAT, 8'h00);
    chk_irq(1'b0);
  endtask

  initial
  begin
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    t_basic();
    t_frame_err_flag();
    t_nine();
    t_addr();
    t_overrun();
    t_enable();
    conclude();
  end
endmodule

`default_nettype wire
